// ===== rtl/dpq_cfg.svh
// How it works
// - dual phase runs only on even channels; the paired odd channel goes inactive
// - uses pulse inputs a and b plus one auxiliary input; counts both ways
// - no counting until the first synchronisation; software must trigger one first
// - every synchronisation loads the count with the preset word
// - on synchronisation the prior count may be stored in capture slot zero
// - gate low ignores both pulse inputs, so only a sync can change the count
// - count is signed 32-bit, full two's-complement range
// - preset lives in a software-writable word, changeable at run time
// - eight decode configurations; up/down pulses after reset
// - up/down: a rising counts up, b rising counts down
// - pulse/direction: a rising counts up with b low, down with b high
// - quadrature x1: a rising with b low up, a falling with b low down
// - x2 adds: a falling with b high up, a rising with b high down
// - x4 adds the b edges qualified by the level of a
// - reverse quadrature swaps up and down of the matching normal mode
// - lock mode: past a limit hold it, drop validity, raise limit flag until preset
// - rollover mode: wrap to opposite limit, set flag, clear on reset command edge
// - sync reference flag set on preset, cleared on sync reset command edge
`ifndef DPQ_CFG_SVH
`define DPQ_CFG_SVH

`define DPQ_CTRL_OFF    12'h000
`define DPQ_PRESET_OFF  12'h004
`define DPQ_COUNT_OFF   12'h008
`define DPQ_CAPT_OFF    12'h00c
`define DPQ_STAT_OFF    12'h010
`define DPQ_IRQ_OFF     12'h014
`define DPQ_MASK_OFF    12'h018

`define DPQ_C_GATE      0
`define DPQ_C_MODE_LO   1
`define DPQ_C_MODE_HI   3
`define DPQ_C_ROLL      4
`define DPQ_C_CAPEN     5
`define DPQ_C_DUAL      6
`define DPQ_C_SYNC      7
`define DPQ_C_SRST      8
`define DPQ_C_MRST      9
`define DPQ_CTRL_W      10
`define DPQ_CTRL_RST    10'h000

`define DPQ_IRQ_W       4
`define DPQ_I_SYNC      0
`define DPQ_I_ROLL      1
`define DPQ_I_HIGH      2
`define DPQ_I_LOW       3

`define DPQ_CNT_MAX     32'sh7fffffff
`define DPQ_CNT_MIN     32'sh80000000

`endif

// ===== rtl/dpq_pkg.sv
package dpq_pkg;
    typedef enum logic [2:0] {
        DPQ_UPDOWN,
        DPQ_PULSE_DIR,
        DPQ_NORM_X1,
        DPQ_NORM_X2,
        DPQ_NORM_X4,
        DPQ_REV_X1,
        DPQ_REV_X2,
        DPQ_REV_X4
    } dpq_mode_t;
endpackage

// ===== rtl/dpq_counter.sv
// Local design decisions: the register addresses and the APB register port.
`include "dpq_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dpq_counter #(
    parameter int unsigned CHANNEL = 0,
    parameter int unsigned ADDR_W  = 12
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    input  wire logic              in_a,
    input  wire logic              in_b,
    input  wire logic              in_aux,
    output var  logic              pair_inactive,
    output var  logic              irq
);
    import dpq_pkg::*;

    localparam logic EVEN_CH = (CHANNEL % 2) == 0;

    // input synchronisers and previous samples
    logic [2:0] sync1, sync2, prev;
    logic [2:0] next_sync1, next_sync2, next_prev;

    // registers
    logic [`DPQ_CTRL_W-1:0] ctrl, ctrl_q;
    logic [31:0]            preset;
    logic [31:0]            capture_slot_zero;
    logic [`DPQ_IRQ_W-1:0]  irq_stat, irq_mask;
    logic signed [31:0]     count;
    logic synced, valid, high_lim, low_lim, roll_flag, sync_ref;
    logic [`DPQ_CTRL_W-1:0] next_ctrl, next_ctrl_q;
    logic [31:0]            next_preset, next_capture;
    logic [`DPQ_IRQ_W-1:0]  next_irq_stat, next_irq_mask;
    logic signed [31:0]     next_count;
    logic next_synced, next_valid, next_high, next_low, next_roll, next_sref;
    logic [31:0] next_prdata;
    logic        next_pready, next_pslverr, next_pair, next_irq;

    // decode
    logic      a_lvl, b_lvl, rise_a, fall_a, rise_b, fall_b;
    logic      up, dn, up_n, dn_n, dual_ok, active;
    logic      sync_edge, srst_edge, mrst_edge, acc, wr, rd, hit;
    dpq_mode_t mode;
    logic [`DPQ_IRQ_W-1:0] irq_ev;

    always_comb begin
        next_sync1 = {in_aux, in_b, in_a};
        next_sync2 = sync1;
        next_prev  = sync2;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            prev  <= 3'h0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            prev  <= next_prev;
        end
    end

    always_comb begin
        a_lvl  = sync2[0];
        b_lvl  = sync2[1];
        rise_a = sync2[0] & ~prev[0];
        fall_a = ~sync2[0] & prev[0];
        rise_b = sync2[1] & ~prev[1];
        fall_b = ~sync2[1] & prev[1];
        mode   = dpq_mode_t'(ctrl[`DPQ_C_MODE_HI:`DPQ_C_MODE_LO]);
        // normal quadrature terms, graded by resolution
        up_n = rise_a & ~b_lvl;
        dn_n = fall_a & ~b_lvl;
        if (mode == DPQ_NORM_X2 || mode == DPQ_NORM_X4 ||
            mode == DPQ_REV_X2 || mode == DPQ_REV_X4) begin
            up_n = up_n | (fall_a & b_lvl);
            dn_n = dn_n | (rise_a & b_lvl);
        end
        if (mode == DPQ_NORM_X4 || mode == DPQ_REV_X4) begin
            up_n = up_n | (rise_b & a_lvl) | (fall_b & ~a_lvl);
            dn_n = dn_n | (rise_b & ~a_lvl) | (fall_b & a_lvl);
        end
        unique case (mode)
            DPQ_UPDOWN: begin
                up = rise_a;
                dn = rise_b;
            end
            DPQ_PULSE_DIR: begin
                up = rise_a & ~b_lvl;
                dn = rise_a & b_lvl;
            end
            DPQ_NORM_X1, DPQ_NORM_X2, DPQ_NORM_X4: begin
                up = up_n;
                dn = dn_n;
            end
            DPQ_REV_X1, DPQ_REV_X2, DPQ_REV_X4: begin
                up = dn_n;
                dn = up_n;
            end
        endcase
    end

    always_comb begin
        dual_ok   = EVEN_CH & ctrl[`DPQ_C_DUAL];
        active    = dual_ok & synced & ctrl[`DPQ_C_GATE];
        sync_edge = dual_ok & ctrl[`DPQ_C_SYNC] & ~ctrl_q[`DPQ_C_SYNC];
        srst_edge = ctrl[`DPQ_C_SRST] & ~ctrl_q[`DPQ_C_SRST];
        mrst_edge = ctrl[`DPQ_C_MRST] & ~ctrl_q[`DPQ_C_MRST];
        acc       = psel & penable & pready;
        wr        = acc & pwrite;
        rd        = psel & ~penable & ~pwrite;
        hit       = (paddr == ADDR_W'(`DPQ_CTRL_OFF))   || (paddr == ADDR_W'(`DPQ_PRESET_OFF)) ||
                    (paddr == ADDR_W'(`DPQ_COUNT_OFF))  || (paddr == ADDR_W'(`DPQ_CAPT_OFF))   ||
                    (paddr == ADDR_W'(`DPQ_STAT_OFF))   || (paddr == ADDR_W'(`DPQ_IRQ_OFF))    ||
                    (paddr == ADDR_W'(`DPQ_MASK_OFF));
    end

    // counting core; simultaneous up and down cancel
    always_comb begin
        next_count   = count;
        next_synced  = synced;
        next_valid   = valid;
        next_high    = high_lim;
        next_low     = low_lim;
        next_roll    = roll_flag;
        next_sref    = sync_ref;
        next_capture = capture_slot_zero;
        irq_ev       = '0;
        if (sync_edge) begin
            if (ctrl[`DPQ_C_CAPEN])
                next_capture = count;
            next_count  = preset;
            next_synced = 1'b1;
            next_valid  = 1'b1;
            next_high   = 1'b0;
            next_low    = 1'b0;
            next_sref   = 1'b1;
            irq_ev[`DPQ_I_SYNC] = 1'b1;
        end else if (active && (up ^ dn)) begin
            if (up) begin
                if (count == `DPQ_CNT_MAX) begin
                    if (ctrl[`DPQ_C_ROLL]) begin
                        next_count = `DPQ_CNT_MIN;
                        next_roll  = 1'b1;
                        irq_ev[`DPQ_I_ROLL] = 1'b1;
                    end else begin
                        next_valid = 1'b0;
                        next_high  = 1'b1;
                        irq_ev[`DPQ_I_HIGH] = 1'b1;
                    end
                end else begin
                    next_count = count + 32'sh1;
                end
            end else begin
                if (count == `DPQ_CNT_MIN) begin
                    if (ctrl[`DPQ_C_ROLL]) begin
                        next_count = `DPQ_CNT_MAX;
                        next_roll  = 1'b1;
                        irq_ev[`DPQ_I_ROLL] = 1'b1;
                    end else begin
                        next_valid = 1'b0;
                        next_low   = 1'b1;
                        irq_ev[`DPQ_I_LOW] = 1'b1;
                    end
                end else begin
                    next_count = count - 32'sh1;
                end
            end
        end
        // a flag event in the clearing cycle survives: set after clear
        if (srst_edge && !sync_edge)
            next_sref = 1'b0;
        if (mrst_edge && !irq_ev[`DPQ_I_ROLL])
            next_roll = 1'b0;
    end

    // register file
    always_comb begin
        next_ctrl     = ctrl;
        next_ctrl_q   = ctrl;
        next_preset   = preset;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        if (wr && paddr == ADDR_W'(`DPQ_CTRL_OFF))
            next_ctrl = pwdata[`DPQ_CTRL_W-1:0];
        if (wr && paddr == ADDR_W'(`DPQ_PRESET_OFF))
            next_preset = pwdata;
        if (wr && paddr == ADDR_W'(`DPQ_MASK_OFF))
            next_irq_mask = pwdata[`DPQ_IRQ_W-1:0];
        if (wr && paddr == ADDR_W'(`DPQ_IRQ_OFF))
            next_irq_stat = irq_stat & ~pwdata[`DPQ_IRQ_W-1:0];
        next_irq_stat = next_irq_stat | irq_ev;
        next_irq      = |(next_irq_stat & next_irq_mask);
        next_pair     = dual_ok;
        // no wait state: pready answers the first access cycle
        next_pready   = psel & ~penable;
        next_pslverr  = psel & ~penable & ~hit;
        next_prdata   = prdata;
        if (rd) begin
            unique case (1'b1)
                paddr == ADDR_W'(`DPQ_CTRL_OFF):   next_prdata = 32'(ctrl);
                paddr == ADDR_W'(`DPQ_PRESET_OFF): next_prdata = preset;
                paddr == ADDR_W'(`DPQ_COUNT_OFF):  next_prdata = count;
                paddr == ADDR_W'(`DPQ_CAPT_OFF):   next_prdata = capture_slot_zero;
                paddr == ADDR_W'(`DPQ_STAT_OFF):   next_prdata = {24'h0, pair_inactive,
                    sync2[2], low_lim, high_lim, valid, sync_ref, roll_flag, synced};
                paddr == ADDR_W'(`DPQ_IRQ_OFF):    next_prdata = 32'(irq_stat);
                paddr == ADDR_W'(`DPQ_MASK_OFF):   next_prdata = 32'(irq_mask);
                default:                           next_prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl              <= `DPQ_CTRL_RST;
            ctrl_q            <= `DPQ_CTRL_RST;
            preset            <= 32'h0;
            capture_slot_zero <= 32'h0;
            irq_stat          <= '0;
            irq_mask          <= '0;
            count             <= 32'sh0;
            synced            <= 1'b0;
            valid             <= 1'b0;
            high_lim          <= 1'b0;
            low_lim           <= 1'b0;
            roll_flag         <= 1'b0;
            sync_ref          <= 1'b0;
            prdata            <= 32'h0;
            pready            <= 1'b0;
            pslverr           <= 1'b0;
            pair_inactive     <= 1'b0;
            irq               <= 1'b0;
        end else begin
            ctrl              <= next_ctrl;
            ctrl_q            <= next_ctrl_q;
            preset            <= next_preset;
            capture_slot_zero <= next_capture;
            irq_stat          <= next_irq_stat;
            irq_mask          <= next_irq_mask;
            count             <= next_count;
            synced            <= next_synced;
            valid             <= next_valid;
            high_lim          <= next_high;
            low_lim           <= next_low;
            roll_flag         <= next_roll;
            sync_ref          <= next_sref;
            prdata            <= next_prdata;
            pready            <= next_pready;
            pslverr           <= next_pslverr;
            pair_inactive     <= next_pair;
            irq               <= next_irq;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_odd_never_runs: assert property (!EVEN_CH |-> !pair_inactive && !active)
        else $error("odd channel ran dual phase");
    a_no_count_unsynced: assert property (!synced && !sync_edge |=> count == $past(count))
        else $error("count moved before first sync");
    a_sync_loads: assert property (sync_edge |=> count == $past(preset) && valid && sync_ref)
        else $error("sync did not load preset");
    a_capture_prior: assert property (sync_edge && ctrl[`DPQ_C_CAPEN]
        |=> capture_slot_zero == $past(count))
        else $error("capture slot missed prior count");
    a_gate_freezes: assert property (!ctrl[`DPQ_C_GATE] && !sync_edge
        |=> count == $past(count))
        else $error("count moved while gate low");
    a_step_up: assert property (active && up && !dn && !sync_edge && count != `DPQ_CNT_MAX
        |=> count == $past(count) + 32'sh1)
        else $error("up step wrong");
    a_step_down: assert property (active && dn && !up && !sync_edge && count != `DPQ_CNT_MIN
        |=> count == $past(count) - 32'sh1)
        else $error("down step wrong");
    a_updown_map: assert property (mode == DPQ_UPDOWN |-> up == rise_a && dn == rise_b)
        else $error("up/down decode wrong");
    a_pdir_map: assert property (mode == DPQ_PULSE_DIR
        |-> up == (rise_a && !b_lvl) && dn == (rise_a && b_lvl))
        else $error("pulse/direction decode wrong");
    a_x1_map: assert property (mode == DPQ_NORM_X1
        |-> up == (rise_a && !b_lvl) && dn == (fall_a && !b_lvl))
        else $error("x1 decode wrong");
    a_x2_extra: assert property (mode == DPQ_NORM_X2 && fall_a && b_lvl |-> up && !dn)
        else $error("x2 decode wrong");
    a_x4_extra: assert property (mode == DPQ_NORM_X4 && rise_b && !a_lvl |-> dn && !up)
        else $error("x4 decode wrong");
    a_rev_swap: assert property (mode == DPQ_REV_X4 |-> up == dn_n && dn == up_n)
        else $error("reverse decode not swapped");
    a_lock_hold: assert property (active && up && !dn && !sync_edge && !ctrl[`DPQ_C_ROLL]
        && count == `DPQ_CNT_MAX |=> count == `DPQ_CNT_MAX && !valid && high_lim)
        else $error("lock at high limit failed");
    a_roll_wrap: assert property (active && dn && !up && !sync_edge && ctrl[`DPQ_C_ROLL]
        && count == `DPQ_CNT_MIN |=> count == `DPQ_CNT_MAX && roll_flag)
        else $error("rollover wrap failed");
    a_sref_clear: assert property (srst_edge && !sync_edge |=> !sync_ref)
        else $error("sync reference not cleared");
    a_edge_latency: assert property ($rose(sync2[0]) |-> $past(sync1[0], 1))
        else $error("pulse input not synchronised");
    a_apb_wait: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

    c_sync_then_count: cover property (sync_edge ##[1:50] (active && up));
    c_rollover: cover property (active && ctrl[`DPQ_C_ROLL] && irq_ev[`DPQ_I_ROLL]);
    c_lock_limit: cover property (irq_ev[`DPQ_I_HIGH] || irq_ev[`DPQ_I_LOW]);
    c_x4_count: cover property (mode == DPQ_NORM_X4 && active && (rise_b || fall_b));
endmodule
`default_nettype wire

// ===== verification/dpq_pulse_source.sv
`timescale 1ns/1ps
`default_nettype none
module dpq_pulse_source #(
    parameter int HOLD = 6
) (
    input  wire logic clk,
    output var  logic in_a,
    output var  logic in_b,
    output var  logic in_aux
);
    initial begin
        in_a = 1'b0;
        in_b = 1'b0;
        in_aux = 1'b0;
    end
    // each level stands HOLD clocks so the two-flop sampler never misses one
    task automatic level(input logic na, input logic nb);
        in_a <= na;
        in_b <= nb;
        repeat (HOLD) @(posedge clk);
    endtask
    task automatic aux(input logic v);
        in_aux <= v;
        repeat (HOLD) @(posedge clk);
    endtask
    // one clean pulse on a (on_a=1) or on b, the other line held low
    task automatic pulse(input logic on_a);
        level(on_a, !on_a);
        level(1'b0, 1'b0);
    endtask
endmodule
`default_nettype wire

// ===== verification/test_dual_phase_quadrature_counter.sv
`include "dpq_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module test_dual_phase_quadrature_counter;
    import dpq_pkg::*;
    logic        clk;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        in_a;
    logic        in_b;
    logic        in_aux;
    logic        pair_inactive;
    logic        irq;
    logic [31:0] rdat;
    logic        rerr;
    int          errors;
    int          checks;

    dpq_counter i_dpq_counter (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_a(in_a), .in_b(in_b), .in_aux(in_aux),
        .pair_inactive(pair_inactive), .irq(irq));
    dpq_pulse_source i_dpq_pulse_source (.clk(clk), .in_a(in_a), .in_b(in_b), .in_aux(in_aux));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // entered just after a rising edge; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so a following call never re-drives psel in this time step
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
        apb(1'b1, ad, wd);
    endtask

    task automatic rd(input logic [11:0] ad);
        apb(1'b0, ad, 32'h0);
    endtask

    // command bits act on a 0->1 write, so the bit is dropped again afterwards
    task automatic sync(input logic [31:0] base, input logic [31:0] pre);
        wr(`DPQ_PRESET_OFF, pre);
        wr(`DPQ_CTRL_OFF, base);
        wr(`DPQ_CTRL_OFF, base | 32'h80);
        wr(`DPQ_CTRL_OFF, base);
    endtask

    task automatic t_reset();
        rd(`DPQ_CTRL_OFF);
        chk(rdat, 32'h0);
        rd(`DPQ_STAT_OFF);
        chk(rdat & 32'h87, 32'h0);
        chk({30'h0, pair_inactive, irq}, 32'h0);
        rd(12'h01c);
        chk({rerr, rdat}, {1'b1, 32'h0});
        wr(12'h01c, 32'h1);
        chk({31'h0, rerr}, 32'h1);
    endtask

    task automatic t_sync();
        wr(`DPQ_CTRL_OFF, 32'h41);
        i_dpq_pulse_source.pulse(1'b1);
        rd(`DPQ_COUNT_OFF);
        chk(rdat, 32'h0);
        chk({31'h0, pair_inactive}, 32'h1);
        wr(`DPQ_MASK_OFF, 32'h1);
        sync(32'h41, 32'h1234_5678);
        rd(`DPQ_COUNT_OFF);
        chk(rdat, 32'h1234_5678);
        rd(`DPQ_STAT_OFF);
        chk(rdat & 32'h5, 32'h5);
        chk({31'h0, irq}, 32'h1);
        wr(`DPQ_IRQ_OFF, 32'h1);
        rd(`DPQ_IRQ_OFF);
        chk({31'h0, irq}, 32'h0);
        wr(`DPQ_CTRL_OFF, 32'h141);
        wr(`DPQ_CTRL_OFF, 32'h41);
        rd(`DPQ_STAT_OFF);
        chk(rdat & 32'h4, 32'h0);
        wr(`DPQ_CTRL_OFF, 32'h61);
        i_dpq_pulse_source.pulse(1'b1);
        sync(32'h61, 32'h5);
        rd(`DPQ_CAPT_OFF);
        chk(rdat, 32'h1234_5679);
        wr(`DPQ_COUNT_OFF, 32'hdead);
        rd(`DPQ_COUNT_OFF);
        chk(rdat, 32'h5);
    endtask

    // forward cycle a+, b+, a-, b- then the backward cycle back to the start
    task automatic t_modes();
        int e1[8] = '{1, 1, 1, 1, 1, -1, -1, -1};
        int ef[8] = '{0, 1, 1, 2, 4, -1, -2, -4};
        dpq_mode_t md;
        for (int m = 0; m < 8; m++) begin
            md = dpq_mode_t'(m);
            sync({25'h0, 3'b100, md, 1'b1}, 32'h0);
            i_dpq_pulse_source.level(1'b1, 1'b0);
            rd(`DPQ_COUNT_OFF);
            chk(rdat, 32'(e1[m]));
            i_dpq_pulse_source.level(1'b1, 1'b1);
            i_dpq_pulse_source.level(1'b0, 1'b1);
            i_dpq_pulse_source.level(1'b0, 1'b0);
            rd(`DPQ_COUNT_OFF);
            chk(rdat, 32'(ef[m]));
            i_dpq_pulse_source.level(1'b0, 1'b1);
            i_dpq_pulse_source.level(1'b1, 1'b1);
            i_dpq_pulse_source.level(1'b1, 1'b0);
            i_dpq_pulse_source.level(1'b0, 1'b0);
            rd(`DPQ_COUNT_OFF);
            chk(rdat, 32'h0);
        end
    endtask

    task automatic t_gate_limits();
        sync(32'h41, 32'd10);
        wr(`DPQ_CTRL_OFF, 32'h40);
        i_dpq_pulse_source.pulse(1'b1);
        i_dpq_pulse_source.pulse(1'b0);
        rd(`DPQ_COUNT_OFF);
        chk(rdat, 32'd10);
        wr(`DPQ_CTRL_OFF, 32'h41);
        i_dpq_pulse_source.pulse(1'b1);
        rd(`DPQ_COUNT_OFF);
        chk(rdat, 32'd11);
        wr(`DPQ_IRQ_OFF, 32'hf);
        sync(32'h41, 32'h7fff_ffff);
        i_dpq_pulse_source.pulse(1'b1);
        rd(`DPQ_COUNT_OFF);
        chk(rdat, 32'h7fff_ffff);
        rd(`DPQ_STAT_OFF);
        chk(rdat & 32'h38, 32'h10);
        rd(`DPQ_IRQ_OFF);
        chk(rdat & 32'h4, 32'h4);
        sync(32'h41, 32'h8000_0000);
        rd(`DPQ_STAT_OFF);
        chk(rdat & 32'h38, 32'h08);
        i_dpq_pulse_source.pulse(1'b0);
        rd(`DPQ_COUNT_OFF);
        chk(rdat, 32'h8000_0000);
        rd(`DPQ_STAT_OFF);
        chk(rdat & 32'h38, 32'h20);
        sync(32'h51, 32'h7fff_ffff);
        i_dpq_pulse_source.pulse(1'b1);
        rd(`DPQ_COUNT_OFF);
        chk(rdat, 32'h8000_0000);
        rd(`DPQ_STAT_OFF);
        chk(rdat & 32'h2, 32'h2);
        wr(`DPQ_CTRL_OFF, 32'h251);
        rd(`DPQ_STAT_OFF);
        chk(rdat & 32'h2, 32'h0);
        i_dpq_pulse_source.aux(1'b1);
        rd(`DPQ_STAT_OFF);
        chk(rdat & 32'h40, 32'h40);
    endtask

    // a full run needs under a thousand clocks; this limit only catches a hang
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        final_report();
    end

    initial begin
        errors = 0;
        checks = 0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset();
        t_sync();
        t_modes();
        t_gate_limits();
        final_report();
    end
endmodule
`default_nettype wire
